/* cpg_pkg.sv */
// Package: register map, field positions, reset values and timing counts
package cpg_pkg;
  // Register byte addresses (printed offsets not all multiples of four: index*4)
  localparam logic [15:0] MCLK_INDEX = 16'h008f;
  localparam logic [15:0] MISC_INDEX = 16'hfff2;
  localparam logic [17:0] MCLK_ADDR = {MCLK_INDEX, 2'b00};
  localparam logic [17:0] MISC_ADDR = {MISC_INDEX, 2'b00};
  localparam logic [17:0] GLOBAL_POWER_DOWN_ADDR = 18'h00100;
  localparam int ADDR_W = 18;
  // Reset values
  localparam logic [7:0] MCLK_RESET = 8'h0a;
  localparam logic [7:0] MISC_RESET = 8'h10;
  // Writable bits
  localparam logic [7:0] MCLK_MASK = 8'hff;
  localparam logic [7:0] MISC_MASK = 8'h37;
  // Field positions, misc power control
  localparam int BIT_SHORTEN_OFF = 5;
  localparam int BIT_LONG_PULSE = 4;
  localparam int BIT_ANALOG_PD = 2;
  localparam int BIT_XCVR_PD = 1;
  localparam int BIT_PULLUP = 0;
  // Field positions, master clock control, and the bit of the global power-down register
  localparam int BIT_FAST_OSC_DIS = 7;
  localparam int BIT_KEYPAD_GATE = 6;
  localparam int BIT_CARD_GATE = 5;
  localparam int BIT_SERIAL_GATE = 4;
  localparam int BIT_SLOW_OSC_DIS = 3;
  localparam int BIT_GLOBAL_PD = 0;
  // Timing
  localparam int CLK_PERIOD_PS = 8000;
  localparam int SHORT_PULSE_PS = 40000;
  localparam int LONG_PULSE_PS = 66000;
  localparam int SHORT_PULSE_CYC = SHORT_PULSE_PS / CLK_PERIOD_PS;
  localparam int LONG_PULSE_CYC = LONG_PULSE_PS / CLK_PERIOD_PS;
  localparam int PD_DELAY_CYC = 32;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

/* cpg_oneshot.sv */
// One-shot that trims the flash read strobe to a fixed width
`timescale 1ns/100ps
`default_nettype none
module cpg_oneshot (
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic strobe_in,
  input wire logic long_sel,
  output logic pulse_out
);
  logic strobe_d;
  logic [3:0] count;
  logic [3:0] width;

  assign width = long_sel ? 4'(cpg_pkg::LONG_PULSE_CYC) : 4'(cpg_pkg::SHORT_PULSE_CYC);

  // ==========================================================
  // Edge detect and width counter
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      strobe_d <= 1'b0;
    end else begin
      strobe_d <= strobe_in;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      count <= 4'h0;
    end else if (strobe_in && !strobe_d) begin
      count <= width;
    end else if (!strobe_in) begin
      count <= 4'h0;
    end else if (count != 4'h0) begin
      count <= count - 4'h1;
    end
  end

  // Pulse ends at the trimmed width or when the strobe drops, whichever first
  assign pulse_out = (strobe_in && !strobe_d) || (count > 4'h1 && strobe_in);
endmodule
`default_nettype wire

/* cpg_clock_power_ctrl.sv */
// Clock and power gating control with AXI4-Lite register access
//
// How it works
// - Shortening off passes read strobe unchanged
// - Shortening on trims strobe via one-shot
// - Long select gives 66 ns, else 40 ns (code: long is 8 cycles of 8 ns, 64 ns)
// - Analog power-down kills regulator and PLL
// - Transceiver enabled while its power-down is 0 (code: global power-down also turns it off)
// - Pull-up connected while connect bit set
// - Misc power register resets to 0x10
// - Fast oscillator disable stops crystal and PLL
// - Keypad gate stops keypad clock, also power-down
// - Card gate stops clock, detection stays alive
// - Serial bus gate stops USB clock, also power-down
// - Slow oscillator disable only, ignores power-down
// - Multiplier field gives ratio 2*value+4
// - Clock control register resets to 0x0a
// - Global power-down stops fast oscillator 32 cycles later
//
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/100ps
`default_nettype none
module cpg_clock_power_ctrl (
  input wire logic clk_sys,
  input wire logic rst_b,
  // AXI4-Lite slave
  input wire logic [17:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [17:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Flash read strobe from the core (same clock domain)
  input wire logic flash_read_in,
  output logic flash_read_out,
  // Analog and clock controls
  output logic internal_regulator_off,
  output logic pll_off,
  output logic fast_oscillator_off,
  output logic slow_oscillator_off,
  output logic transceiver_off,
  output logic bus_pullup_on,
  output logic keypad_clock_off,
  output logic card_clock_off,
  output logic serial_bus_clock_off,
  output logic card_detect_enable,
  output logic [2:0] pll_multiplier_value,
  output logic [4:0] pll_ratio
);
  logic [7:0] master_clock_control;
  logic [7:0] misc_power_control;
  logic global_power_down;
  logic [5:0] pd_count;
  logic pd_active;
  logic aw_held;
  logic w_held;
  logic [17:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic do_write;
  logic trimmed;
  logic next_flash_read;
  logic [6:0] pd_watch;

  // ==========================================================
  // AXI4-Lite write channel
  assign do_write = aw_held && w_held && !s_axi_bvalid;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 18'h00000;
      s_axi_awready <= 1'b1;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
      s_axi_awready <= 1'b0;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end else if (!aw_held && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_wready <= 1'b1;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
      s_axi_wready <= 1'b0;
    end else if (do_write) begin
      w_held <= 1'b0;
    end else if (!w_held && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= cpg_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr == cpg_pkg::MCLK_ADDR || aw_addr == cpg_pkg::MISC_ADDR ||
          aw_addr == cpg_pkg::GLOBAL_POWER_DOWN_ADDR) begin
        s_axi_bresp <= cpg_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= cpg_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      master_clock_control <= cpg_pkg::MCLK_RESET;
      misc_power_control <= cpg_pkg::MISC_RESET;
      global_power_down <= 1'b0;
    end else if (do_write && w_strb[0]) begin
      if (aw_addr == cpg_pkg::MCLK_ADDR) begin
        master_clock_control <= w_data[7:0] & cpg_pkg::MCLK_MASK;
      end
      if (aw_addr == cpg_pkg::MISC_ADDR) begin
        misc_power_control <= w_data[7:0] & cpg_pkg::MISC_MASK;
      end
      if (aw_addr == cpg_pkg::GLOBAL_POWER_DOWN_ADDR) begin
        global_power_down <= w_data[cpg_pkg::BIT_GLOBAL_PD];
      end
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= cpg_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= cpg_pkg::RESP_OKAY;
      if (s_axi_araddr == cpg_pkg::MCLK_ADDR) begin
        s_axi_rdata <= {24'h000000, master_clock_control};
      end else if (s_axi_araddr == cpg_pkg::MISC_ADDR) begin
        s_axi_rdata <= {24'h000000, misc_power_control};
      end else if (s_axi_araddr == cpg_pkg::GLOBAL_POWER_DOWN_ADDR) begin
        s_axi_rdata <= {24'h000000, pd_active, 6'h00, global_power_down};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= cpg_pkg::RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ==========================================================
  // Global power-down delay
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pd_count <= 6'h00;
      pd_active <= 1'b0;
    end else if (!global_power_down) begin
      pd_count <= 6'h00;
      pd_active <= 1'b0;
    end else if (pd_count == 6'(cpg_pkg::PD_DELAY_CYC - 1)) begin
      pd_active <= 1'b1;
    end else begin
      pd_count <= pd_count + 6'h01;
    end
  end

  // ==========================================================
  // Flash read strobe shaping
  cpg_oneshot u_oneshot (
    .clk_sys(clk_sys),
    .rst_b(rst_b),
    .strobe_in(flash_read_in),
    .long_sel(misc_power_control[cpg_pkg::BIT_LONG_PULSE]),
    .pulse_out(trimmed)
  );

  always_comb begin
    if (misc_power_control[cpg_pkg::BIT_SHORTEN_OFF]) begin
      next_flash_read = flash_read_in;
    end else begin
      next_flash_read = trimmed;
    end
  end

  // ==========================================================
  // Gate and enable outputs
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      flash_read_out <= 1'b0;
      internal_regulator_off <= 1'b0;
      pll_off <= 1'b0;
      fast_oscillator_off <= 1'b0;
      slow_oscillator_off <= 1'b1;
      transceiver_off <= 1'b0;
      bus_pullup_on <= 1'b0;
      keypad_clock_off <= 1'b0;
      card_clock_off <= 1'b0;
      serial_bus_clock_off <= 1'b0;
      card_detect_enable <= 1'b1;
      pll_multiplier_value <= 3'h2;
      pll_ratio <= 5'h08;
    end else begin
      flash_read_out <= next_flash_read;
      internal_regulator_off <= misc_power_control[cpg_pkg::BIT_ANALOG_PD] || pd_active;
      pll_off <= misc_power_control[cpg_pkg::BIT_ANALOG_PD] ||
                 master_clock_control[cpg_pkg::BIT_FAST_OSC_DIS] || pd_active;
      fast_oscillator_off <= master_clock_control[cpg_pkg::BIT_FAST_OSC_DIS] || pd_active;
      slow_oscillator_off <= master_clock_control[cpg_pkg::BIT_SLOW_OSC_DIS];
      transceiver_off <= misc_power_control[cpg_pkg::BIT_XCVR_PD] || pd_active;
      bus_pullup_on <= misc_power_control[cpg_pkg::BIT_PULLUP];
      keypad_clock_off <= master_clock_control[cpg_pkg::BIT_KEYPAD_GATE] || pd_active;
      card_clock_off <= master_clock_control[cpg_pkg::BIT_CARD_GATE] || pd_active;
      serial_bus_clock_off <= master_clock_control[cpg_pkg::BIT_SERIAL_GATE] || pd_active;
      card_detect_enable <= 1'b1;
      pll_multiplier_value <= master_clock_control[2:0];
      pll_ratio <= {1'b0, master_clock_control[2:0], 1'b0} + 5'h04;
    end
  end

  // ==========================================================
  // Assertions
  AST_PASS_THROUGH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    misc_power_control[cpg_pkg::BIT_SHORTEN_OFF] |=> flash_read_out == $past(flash_read_in))
    else $error("strobe not passed through");
  AST_SHORT_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!misc_power_control[5] && !misc_power_control[4] && $rose(flash_read_in)) ##1
    flash_read_in [*6] |-> ##1 !flash_read_out)
    else $error("short pulse too long");
  AST_TRIM_ON: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!misc_power_control[5] && $rose(flash_read_in)) |=> flash_read_out)
    else $error("trimmed pulse missing");
  AST_PLL_ANALOG: assert property (@(posedge clk_sys) disable iff (!rst_b)
    misc_power_control[cpg_pkg::BIT_ANALOG_PD] |=> pll_off && internal_regulator_off)
    else $error("analog power-down ignored");
  AST_XCVR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pd_active |=> transceiver_off == $past(misc_power_control[1]))
    else $error("transceiver control wrong");
  AST_PULLUP: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 bus_pullup_on == $past(misc_power_control[0]))
    else $error("pull-up control wrong");
  AST_PD_DELAY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    $rose(global_power_down) |-> !pd_active [*8] ##24 !pd_active ##1 pd_active)
    else $error("power-down delay wrong");
  AST_PD_GATES: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pd_active |=> keypad_clock_off && card_clock_off && serial_bus_clock_off &&
    fast_oscillator_off)
    else $error("gates not forced by power-down");
  AST_SLOW_OSC: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 slow_oscillator_off == $past(master_clock_control[3]))
    else $error("slow oscillator follows power-down");
  AST_RATIO: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 pll_ratio == 5'($past(master_clock_control[2:0]) * 2 + 4))
    else $error("pll ratio wrong");
  AST_RESERVED: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (misc_power_control & ~cpg_pkg::MISC_MASK) == 8'h00)
    else $error("reserved bits set");

  // ==========================================================
  // Cycles since the power-down request was stored, for the exact delay check
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      pd_watch <= 7'h00;
    end else if (!global_power_down) begin
      pd_watch <= 7'h00;
    end else if (pd_watch != 7'h7f) begin
      pd_watch <= pd_watch + 7'h01;
    end
  end

  AST_PD_EXACT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    global_power_down |-> pd_active == (pd_watch >= 7'(cpg_pkg::PD_DELAY_CYC)))
    else $error("power-down delay not exact");
  AST_PD_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !global_power_down |=> !pd_active)
    else $error("power-down not released");
  AST_PD_REG_OFF: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pd_active |=> internal_regulator_off && pll_off && transceiver_off)
    else $error("analog not forced by power-down");
  AST_PD_BITS_KEPT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    pd_active && !do_write |=> master_clock_control == $past(master_clock_control))
    else $error("power-down altered clock control bits");

  // Per-gate checks outside power-down, then multiplier, long pulse and register access checks
  AST_FAST_OSC: assert property (@(posedge clk_sys) disable iff (!rst_b)
    master_clock_control[cpg_pkg::BIT_FAST_OSC_DIS] |=> fast_oscillator_off && pll_off)
    else $error("fast oscillator disable ignored");
  AST_KEYPAD_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pd_active |=> keypad_clock_off == $past(master_clock_control[cpg_pkg::BIT_KEYPAD_GATE]))
    else $error("keypad gate wrong");
  AST_CARD_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pd_active |=> card_clock_off == $past(master_clock_control[cpg_pkg::BIT_CARD_GATE]))
    else $error("card gate wrong");
  AST_CARD_DETECT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    card_clock_off |-> card_detect_enable)
    else $error("card detection lost with clock gated");
  AST_SERIAL_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    !pd_active |=> serial_bus_clock_off == $past(master_clock_control[cpg_pkg::BIT_SERIAL_GATE]))
    else $error("serial bus gate wrong");
  AST_MULT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 pll_multiplier_value == $past(master_clock_control[2:0]))
    else $error("multiplier value wrong");
  AST_LONG_WIDTH: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (!misc_power_control[cpg_pkg::BIT_SHORTEN_OFF] &&
     misc_power_control[cpg_pkg::BIT_LONG_PULSE] && $rose(flash_read_in)) ##1
    flash_read_in [*8] |-> flash_read_out ##1 !flash_read_out)
    else $error("long pulse width wrong");
  AST_UNMAPPED_WR: assert property (@(posedge clk_sys) disable iff (!rst_b)
    do_write && aw_addr != cpg_pkg::MCLK_ADDR && aw_addr != cpg_pkg::MISC_ADDR &&
    aw_addr != cpg_pkg::GLOBAL_POWER_DOWN_ADDR |=> s_axi_bvalid && s_axi_bresp == cpg_pkg::RESP_SLVERR)
    else $error("unmapped write not refused");
  AST_MISC_WRITE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    do_write && w_strb[0] && aw_addr == cpg_pkg::MISC_ADDR |=>
    misc_power_control == ($past(w_data[7:0]) & cpg_pkg::MISC_MASK))
    else $error("misc write not masked");
  AST_READ_UPPER: assert property (@(posedge clk_sys) disable iff (!rst_b)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");
endmodule
`default_nettype wire

/* cpg_clock_power_ctrl_tb.sv */
// Testbench: register access, output controls, read strobe shaping, power-down
`timescale 1ns/100ps
`default_nettype none
module cpg_clock_power_ctrl_tb;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [17:0] s_axi_awaddr = 18'h00000;
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [1:0] s_axi_bresp;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [17:0] s_axi_araddr = 18'h00000;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic flash_read_in = 1'b0;
  logic flash_read_out, internal_regulator_off, pll_off, fast_oscillator_off;
  logic slow_oscillator_off, transceiver_off, bus_pullup_on, keypad_clock_off;
  logic card_clock_off, serial_bus_clock_off, card_detect_enable;
  logic [2:0] pll_multiplier_value;
  logic [4:0] pll_ratio;
  logic [9:0] outs;
  logic [1:0] resp;
  int n_fail = 0;
  int checks = 0;
  int cyc = 0;
  int n;

  cpg_clock_power_ctrl DUT (.clk_sys, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .flash_read_in, .flash_read_out, .internal_regulator_off,
    .pll_off, .fast_oscillator_off, .slow_oscillator_off, .transceiver_off, .bus_pullup_on,
    .keypad_clock_off, .card_clock_off, .serial_bus_clock_off, .card_detect_enable,
    .pll_multiplier_value, .pll_ratio);

  // Output bundle: regulator, pll, fast, slow, xcvr, pullup, keypad, card, serial, detect
  assign outs = {internal_regulator_off, pll_off, fast_oscillator_off, slow_oscillator_off,
    transceiver_off, bus_pullup_on, keypad_clock_off, card_clock_off, serial_bus_clock_off,
    card_detect_enable};

  always #4 clk_sys = ~clk_sys;

  // ==========================================
  // Checking and closing
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d n_fail=%0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end

  // ==========================================
  // AXI4-Lite master
  task automatic axi_wr(input logic [17:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_on;
    logic w_on;
    logic done;
    aw_on = 1'b1;
    w_on = 1'b1;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (aw_on && s_axi_awready === 1'b1) begin
        s_axi_awvalid <= 1'b0;
        aw_on = 1'b0;
      end
      if (w_on && s_axi_wready === 1'b1) begin
        s_axi_wvalid <= 1'b0;
        w_on = 1'b0;
      end
      if (s_axi_bvalid === 1'b1) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic axi_rd(input logic [17:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_on;
    logic done;
    ar_on = 1'b1;
    done = 1'b0;
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!done) begin
      @(posedge clk_sys);
      if (ar_on && s_axi_arready === 1'b1) begin
        s_axi_arvalid <= 1'b0;
        ar_on = 1'b0;
      end
      if (s_axi_rvalid === 1'b1) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end
    end
  endtask

  task automatic rd_chk(input logic [17:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axi_rd(a, d, r);
    chk(d, exp);
    chk({30'h0, r}, {30'h0, er});
  endtask

  task automatic wr_set(input logic [17:0] a, input logic [7:0] d);
    logic [1:0] r;
    axi_wr(a, d, r);
    chk({30'h0, r}, {30'h0, cpg_pkg::RESP_OKAY});
    repeat (3) @(posedge clk_sys);
  endtask

  // Read strobe held high for len cycles; counts cycles the shaped strobe is high
  task automatic pulse_cnt(input int len, output int cnt);
    cnt = 0;
    for (int i = 0; i < len + 4; i++) begin
      @(posedge clk_sys);
      flash_read_in <= (i < len);
      if (flash_read_out === 1'b1) cnt++;
    end
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(cpg_pkg::MCLK_ADDR, 32'h0000000a, cpg_pkg::RESP_OKAY);
    rd_chk(cpg_pkg::MISC_ADDR, 32'h00000010, cpg_pkg::RESP_OKAY);
    chk({22'h0, outs}, 32'h00000041);
    chk({27'h0, pll_ratio}, 32'h00000008);
    wr_set(cpg_pkg::MISC_ADDR, 8'hff);
    rd_chk(cpg_pkg::MISC_ADDR, 32'h00000037, cpg_pkg::RESP_OKAY);
    chk({22'h0, outs}, 32'h00000371);
    wr_set(cpg_pkg::MISC_ADDR, 8'h00);
    chk({22'h0, outs}, 32'h00000041);
    pulse_cnt(12, n);
    chk(32'(n), 32'd5);
    wr_set(cpg_pkg::MISC_ADDR, 8'h10);
    pulse_cnt(12, n);
    chk(32'(n), 32'd8);
    wr_set(cpg_pkg::MISC_ADDR, 8'h20);
    pulse_cnt(12, n);
    chk(32'(n), 32'd12);
    for (int v = 0; v < 8; v++) begin
      wr_set(cpg_pkg::MCLK_ADDR, 8'(v));
      chk({29'h0, pll_multiplier_value}, 32'(v));
      chk({27'h0, pll_ratio}, 32'(2 * v + 4));
    end
    chk({22'h0, outs}, 32'h00000001);
    wr_set(cpg_pkg::MCLK_ADDR, 8'hff);
    rd_chk(cpg_pkg::MCLK_ADDR, 32'h000000ff, cpg_pkg::RESP_OKAY);
    chk({22'h0, outs}, 32'h000001cf);
    axi_wr(18'h00004, 8'h55, resp);
    chk({30'h0, resp}, {30'h0, cpg_pkg::RESP_SLVERR});
    rd_chk(18'h00004, 32'h00000000, cpg_pkg::RESP_SLVERR);
    wr_set(cpg_pkg::MCLK_ADDR, 8'h00);
    wr_set(cpg_pkg::MISC_ADDR, 8'h01);
    chk({22'h0, outs}, 32'h00000011);
    axi_wr(cpg_pkg::GLOBAL_POWER_DOWN_ADDR, 8'h01, resp);
    chk({30'h0, resp}, {30'h0, cpg_pkg::RESP_OKAY});
    repeat (20) @(posedge clk_sys);
    chk({22'h0, outs}, 32'h00000011);
    repeat (20) @(posedge clk_sys);
    chk({22'h0, outs}, 32'h000003bf);
    rd_chk(cpg_pkg::GLOBAL_POWER_DOWN_ADDR, 32'h00000081, cpg_pkg::RESP_OKAY);
    rd_chk(cpg_pkg::MCLK_ADDR, 32'h00000000, cpg_pkg::RESP_OKAY);
    rd_chk(cpg_pkg::MISC_ADDR, 32'h00000001, cpg_pkg::RESP_OKAY);
    wr_set(cpg_pkg::GLOBAL_POWER_DOWN_ADDR, 8'h00);
    chk({22'h0, outs}, 32'h00000011);
    s_axi_wstrb <= 4'he;
    wr_set(cpg_pkg::MISC_ADDR, 8'h36);
    s_axi_wstrb <= 4'hf;
    rd_chk(cpg_pkg::MISC_ADDR, 32'h00000001, cpg_pkg::RESP_OKAY);
    chk({22'h0, outs}, 32'h00000011);
    rst_b <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    rd_chk(cpg_pkg::MISC_ADDR, 32'h00000010, cpg_pkg::RESP_OKAY);
    chk({22'h0, outs}, 32'h00000041);
    close_out();
  end
endmodule
`default_nettype wire
